//--- cstc_cfg.svh
// Offsets, field positions, reset values and decode constants
`ifndef CSTC_CFG_SVH
`define CSTC_CFG_SVH

`define CSTC_ADDR_STEP0 8'h13
`define CSTC_ADDR_STEP1 8'h14
`define CSTC_ADDR_THM0 8'h15

`define CSTC_RST_STEP0 8'h00
`define CSTC_RST_STEP1 8'h00
`define CSTC_RST_THM0 8'h00

`define CSTC_MASK_STEP0 8'h7F
`define CSTC_MASK_STEP1 8'h1F
`define CSTC_MASK_THM0 8'h7F

`define CSTC_HYS_LSB 4
`define CSTC_RISE_LSB 0
`define CSTC_UVLO_LSB 3
`define CSTC_ISTEP_LSB 0
`define CSTC_THMEN_LSB 5
`define CSTC_COOLREG_LSB 3
`define CSTC_COOLFCHG_LSB 0

`define CSTC_RISE_BASE_MV 13'h0ED8
`define CSTC_RISE_STEP_MV 13'h0032
`define CSTC_HYS_STEP_MV 13'h0064
`define CSTC_HYS_MAX_CODE 3'h5

`define CSTC_SCALE_BASE 4'h2
`define CSTC_SCALE_FULL 4'hA
`define CSTC_SCALE_TOP_CODE 3'h7

`define CSTC_COOL_OFS_00 13'h0096
`define CSTC_COOL_OFS_01 13'h0064
`define CSTC_COOL_OFS_10 13'h0032
`define CSTC_COOL_OFS_11 13'h0000

`define CSTC_ZONE_COLD 3'h0
`define CSTC_ZONE_COOL 3'h1
`define CSTC_ZONE_ROOM 3'h2
`define CSTC_ZONE_WARM 3'h3
`define CSTC_ZONE_HOT 3'h4

`define CSTC_THM_OFF 2'h0
`define CSTC_THM_COOL_ROOM 2'h1
`define CSTC_THM_ROOM_WARM 2'h2
`define CSTC_THM_ALL 2'h3

`endif

//--- cstc_pkg.sv
// Types shared by the step-charge and thermistor configuration block
package cstc_pkg;

  typedef enum logic [1:0] {
    CSTC_STEP_FULL = 2'b01,
    CSTC_STEP_REDUCED = 2'b10
  } cstc_step_type;

  typedef struct packed {
    logic [7:0] step_cfg0_reg;
    logic [7:0] step_cfg1_reg;
    logic [7:0] thm_cfg0_reg;
    logic [7:0] rdata_reg;
    logic sup_meta_reg;
    logic sup_sync_reg;
    cstc_step_type step_reg;
    logic [3:0] scale_reg;
    logic [12:0] vreg_reg;
    logic allow_reg;
    logic mon_reg;
  } cstc_state_type;

endpackage : cstc_pkg

//--- cstc_scale.sv
// Current-scale code to tenths of nominal fast-charge current
`timescale 1ns/1ps
`default_nettype none
`include "cstc_cfg.svh"

module cstc_scale (
  input wire logic [2:0] code,
  output logic [3:0] tenths
);

  always_comb begin
    if (code == `CSTC_SCALE_TOP_CODE) begin
      tenths = `CSTC_SCALE_FULL;
    end else begin
      tenths = `CSTC_SCALE_BASE + {1'b0, code};
    end
  end

endmodule : cstc_scale
`default_nettype wire

//--- cstc_top.sv
// Step-charge and cool-zone thermistor configuration registers and control
// Operation
// RULE1 - Hysteresis code 0-5 selects 100-600 mV; codes 6 and 7 reserved.
// RULE2 - Rising threshold is 3.80 V plus 50 mV per code step.
// RULE3 - Above threshold, current is the minimum of step scale and zone scale.
// RULE4 - Thermistor monitoring mode acts only while input supply present.
// RULE5 - Mode 11 monitors while input supply present and allows charging in cool, room, warm.
// RULE6 - Cool zone lowers regulation target by 150, 100, 50 or 0 mV.
// RULE7 - Cool zone current scale: codes 0-6 give 0.2-0.8, code 7 gives 1.0.
// RULE8 - Full current returns only below rising threshold minus hysteresis.
`timescale 1ns/1ps
`default_nettype none
`include "cstc_cfg.svh"

module cstc_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic charger_input_supply,
  input wire logic [12:0] vbat_mv,
  input wire logic [12:0] base_vreg_setting,
  input wire logic [2:0] thermal_zone,
  output logic step_reduced,
  output logic [3:0] fast_charge_scale,
  output logic [12:0] vreg_target_mv,
  output logic charge_allowed,
  output logic monitor_active,
  output logic [1:0] system_undervoltage_sel
);

  cstc_pkg::cstc_state_type s;
  cstc_pkg::cstc_state_type n;

  logic [2:0] step_hysteresis_sel;
  logic [3:0] step_rise_threshold_sel;
  logic [2:0] step_current_code;
  logic [1:0] thermistor_monitor_mode;
  logic [1:0] cool_zone_vreg_offset;
  logic [2:0] cool_zone_current_code;
  logic [3:0] step_current_scale;
  logic [3:0] cool_zone_current_scale;
  logic [12:0] rise_mv;
  logic [12:0] hys_mv;
  logic [12:0] fall_mv;
  logic [12:0] cool_ofs_mv;
  logic [2:0] hys_code_eff;
  logic mon_on;
  logic cool_applied;
  logic zone_ok;
  logic [3:0] step_lim;
  logic [3:0] zone_lim;

  assign step_hysteresis_sel = s.step_cfg0_reg[`CSTC_HYS_LSB +: 3];
  assign step_rise_threshold_sel = s.step_cfg0_reg[`CSTC_RISE_LSB +: 4];
  assign step_current_code = s.step_cfg1_reg[`CSTC_ISTEP_LSB +: 3];
  assign thermistor_monitor_mode = s.thm_cfg0_reg[`CSTC_THMEN_LSB +: 2];
  assign cool_zone_vreg_offset = s.thm_cfg0_reg[`CSTC_COOLREG_LSB +: 2];
  assign cool_zone_current_code = s.thm_cfg0_reg[`CSTC_COOLFCHG_LSB +: 3];

  cstc_scale u_step_scale (
    .code(step_current_code),
    .tenths(step_current_scale)
  );

  cstc_scale u_cool_scale (
    .code(cool_zone_current_code),
    .tenths(cool_zone_current_scale)
  );

  always_comb begin
    n = s;
    // Reserved hysteresis codes saturate at the largest legal step
    hys_code_eff = (step_hysteresis_sel > `CSTC_HYS_MAX_CODE) ?
                   `CSTC_HYS_MAX_CODE : step_hysteresis_sel; // [RULE1]
    hys_mv = ({10'h000, hys_code_eff} + 13'h0001) *
             `CSTC_HYS_STEP_MV; // [RULE1]
    rise_mv = `CSTC_RISE_BASE_MV +
              {9'h000, step_rise_threshold_sel} *
              `CSTC_RISE_STEP_MV; // [RULE2]
    fall_mv = rise_mv - hys_mv; // [RULE8]
    case (cool_zone_vreg_offset)
      2'h0: cool_ofs_mv = `CSTC_COOL_OFS_00; // [RULE6]
      2'h1: cool_ofs_mv = `CSTC_COOL_OFS_01;
      2'h2: cool_ofs_mv = `CSTC_COOL_OFS_10;
      default: cool_ofs_mv = `CSTC_COOL_OFS_11;
    endcase
    mon_on = s.sup_sync_reg &&
             (thermistor_monitor_mode != `CSTC_THM_OFF); // [RULE4]
    case (thermal_zone)
      `CSTC_ZONE_COOL: begin
        zone_ok = (thermistor_monitor_mode == `CSTC_THM_COOL_ROOM) ||
                  (thermistor_monitor_mode == `CSTC_THM_ALL); // [RULE5]
      end
      `CSTC_ZONE_ROOM: zone_ok = 1'b1; // [RULE5]
      `CSTC_ZONE_WARM: begin
        zone_ok = (thermistor_monitor_mode == `CSTC_THM_ROOM_WARM) ||
                  (thermistor_monitor_mode == `CSTC_THM_ALL); // [RULE5]
      end
      default: zone_ok = 1'b0;
    endcase
    cool_applied = mon_on && zone_ok &&
                   (thermal_zone == `CSTC_ZONE_COOL); // [RULE6]

    // Pin synchroniser for the supply-present level
    n.sup_meta_reg = charger_input_supply;
    n.sup_sync_reg = s.sup_meta_reg;

    // Register writes; unused bits stay zero
    if (reg_wr) begin
      case (reg_addr)
        `CSTC_ADDR_STEP0: n.step_cfg0_reg = reg_wdata & `CSTC_MASK_STEP0;
        `CSTC_ADDR_STEP1: n.step_cfg1_reg = reg_wdata & `CSTC_MASK_STEP1;
        `CSTC_ADDR_THM0: n.thm_cfg0_reg = reg_wdata & `CSTC_MASK_THM0;
        default: n.step_cfg0_reg = s.step_cfg0_reg;
      endcase
    end
    // Reads return pre-write contents; unmapped reads give zero
    if (reg_rd) begin
      case (reg_addr)
        `CSTC_ADDR_STEP0: n.rdata_reg = s.step_cfg0_reg;
        `CSTC_ADDR_STEP1: n.rdata_reg = s.step_cfg1_reg;
        `CSTC_ADDR_THM0: n.rdata_reg = s.thm_cfg0_reg;
        default: n.rdata_reg = 8'h00;
      endcase
    end

    case (s.step_reg)
      cstc_pkg::CSTC_STEP_FULL: begin
        if (vbat_mv > rise_mv) begin
          n.step_reg = cstc_pkg::CSTC_STEP_REDUCED; // [RULE2]
        end
      end
      cstc_pkg::CSTC_STEP_REDUCED: begin
        if (vbat_mv < fall_mv) begin
          n.step_reg = cstc_pkg::CSTC_STEP_FULL; // [RULE8]
        end
      end
      default: n.step_reg = cstc_pkg::CSTC_STEP_FULL;
    endcase

    step_lim = (n.step_reg == cstc_pkg::CSTC_STEP_REDUCED) ?
               step_current_scale : `CSTC_SCALE_FULL;
    zone_lim = cool_applied ? cool_zone_current_scale :
               `CSTC_SCALE_FULL; // [RULE7]
    n.scale_reg = (step_lim < zone_lim) ? step_lim : zone_lim; // [RULE3]
    // Outside the cool reduction the base target passes unchanged
    n.vreg_reg = cool_applied ? (base_vreg_setting - cool_ofs_mv) :
                 base_vreg_setting; // [RULE6]
    n.allow_reg = !mon_on || zone_ok; // [RULE4] [RULE5]
    n.mon_reg = mon_on; // [RULE4]
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s.step_cfg0_reg <= `CSTC_RST_STEP0;
      s.step_cfg1_reg <= `CSTC_RST_STEP1;
      s.thm_cfg0_reg <= `CSTC_RST_THM0;
      s.rdata_reg <= 8'h00;
      s.sup_meta_reg <= 1'b0;
      s.sup_sync_reg <= 1'b0;
      s.step_reg <= cstc_pkg::CSTC_STEP_FULL;
      s.scale_reg <= `CSTC_SCALE_FULL;
      s.vreg_reg <= 13'h0000;
      s.allow_reg <= 1'b1;
      s.mon_reg <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata_reg;
  assign step_reduced = (s.step_reg == cstc_pkg::CSTC_STEP_REDUCED);
  assign fast_charge_scale = s.scale_reg;
  assign vreg_target_mv = s.vreg_reg;
  assign charge_allowed = s.allow_reg;
  assign monitor_active = s.mon_reg;
  assign system_undervoltage_sel = s.step_cfg1_reg[`CSTC_UVLO_LSB +: 2];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_HYS_RANGE: assert property ( // [RULE1]
    (hys_mv >= 13'h0064) && (hys_mv <= 13'h0258) &&
    ((step_hysteresis_sel > 3'h5) || (hys_mv ==
      ({10'h000, step_hysteresis_sel} + 13'h0001) * 13'h0064)))
    else $error("Hysteresis outside 100 to 600 mV");
  AST_RISE_ENTER: assert property ( // [RULE2]
    (s.step_reg == cstc_pkg::CSTC_STEP_FULL) &&
    (vbat_mv > 13'h0ED8 + {9'h000, step_rise_threshold_sel} * 13'h0032)
    |=> step_reduced)
    else $error("Step reduction not entered above threshold");
  AST_RISE_HOLD: assert property ( // [RULE2]
    (s.step_reg == cstc_pkg::CSTC_STEP_FULL) && (vbat_mv <= rise_mv)
    |=> !step_reduced)
    else $error("Step reduction entered below threshold");
  AST_STEP_MIN: assert property ( // [RULE3]
    step_reduced |-> (fast_charge_scale <= $past(step_current_scale)))
    else $error("Reduced current above step scale");
  AST_NO_SUPPLY: assert property ( // [RULE4]
    !s.sup_sync_reg |=> !monitor_active && charge_allowed)
    else $error("Monitoring active without input supply");
  AST_MODE_ALL: assert property ( // [RULE5]
    s.sup_sync_reg && (thermistor_monitor_mode == 2'h3) &&
    (thermal_zone inside {3'h1, 3'h2, 3'h3})
    |=> monitor_active && charge_allowed)
    else $error("Charging blocked in an allowed zone");
  AST_COOL_VREG: assert property ( // [RULE6]
    cool_applied |=> vreg_target_mv ==
      $past(base_vreg_setting) - $past(cool_ofs_mv))
    else $error("Cool zone regulation target wrong");
  AST_COOL_SCALE: assert property ( // [RULE7]
    cool_applied |=> fast_charge_scale <= $past(cool_zone_current_scale))
    else $error("Cool zone current above scale");
  AST_FALL_HOLD: assert property ( // [RULE8]
    step_reduced && (vbat_mv >= fall_mv) |=> step_reduced)
    else $error("Full current restored inside hysteresis band");
  AST_FALL_EXIT: assert property ( // [RULE8]
    step_reduced && (vbat_mv < fall_mv) |=> !step_reduced)
    else $error("Full current not restored below band");

  COV_STEP_ENTER: cover property (!step_reduced ##1 step_reduced);
  COV_STEP_EXIT: cover property (step_reduced ##1 !step_reduced);
  COV_COOL: cover property (cool_applied ##1 fast_charge_scale < 4'hA);
  COV_BLOCKED: cover property (monitor_active && !charge_allowed);

endmodule : cstc_top
`default_nettype wire

//--- cstc_top_test.sv
// Self-checking bench for the step-charge and thermistor config block
`timescale 1ns/1ps
`default_nettype none

module cstc_top_test;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic charger_input_supply = 1'b0;
  logic [12:0] vbat_mv = 13'h0E10;
  logic [12:0] base_vreg_setting = 13'h1068;
  logic [2:0] thermal_zone = 3'h2;
  logic step_reduced;
  logic [3:0] fast_charge_scale;
  logic [12:0] vreg_target_mv;
  logic charge_allowed;
  logic monitor_active;
  logic [1:0] system_undervoltage_sel;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] seed = 32'h0000B337;
  logic [7:0] s0 = 8'h00;
  logic [7:0] s1 = 8'h00;
  logic [7:0] t0 = 8'h00;
  logic st = 1'b0;
  logic [7:0] rv;
  logic [31:0] r;

  cstc_top uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .charger_input_supply(charger_input_supply),
    .vbat_mv(vbat_mv), .base_vreg_setting(base_vreg_setting),
    .thermal_zone(thermal_zone), .step_reduced(step_reduced),
    .fast_charge_scale(fast_charge_scale), .vreg_target_mv(vreg_target_mv),
    .charge_allowed(charge_allowed), .monitor_active(monitor_active),
    .system_undervoltage_sel(system_undervoltage_sel));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [3:0] scl(input logic [2:0] c);
    return (c == 3'h7) ? 4'hA : {1'b0, c} + 4'h2;
  endfunction : scl

  function automatic logic [12:0] rise_mv();
    return 13'h0ED8 + 13'h0032 * {9'h000, s0[3:0]};
  endfunction : rise_mv

  function automatic logic [12:0] hys_mv();
    if (s0[6:4] > 3'h5) return 13'h0258;
    return 13'h0064 * ({10'h000, s0[6:4]} + 13'h0001);
  endfunction : hys_mv

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic upd();
    if (!st && vbat_mv > rise_mv()) st = 1'b1;
    else if (st && vbat_mv < rise_mv() - hys_mv()) st = 1'b0;
  endtask : upd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    if (a == 8'h13) s0 = d & 8'h7F;
    if (a == 8'h14) s1 = d & 8'h1F;
    if (a == 8'h15) t0 = d & 8'h7F;
    upd();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic chk_out();
    logic mon;
    logic cool;
    logic ok;
    logic [3:0] zs;
    logic [3:0] ss;
    logic [12:0] vx;
    mon = charger_input_supply && (t0[6:5] != 2'h0);
    cool = mon && thermal_zone == 3'h1 && t0[5];
    case (thermal_zone)
      3'h1: ok = t0[5];
      3'h2: ok = 1'b1;
      3'h3: ok = t0[6];
      default: ok = 1'b0;
    endcase
    if (!mon) ok = 1'b1;
    zs = cool ? scl(t0[2:0]) : 4'hA;
    ss = scl(s1[2:0]);
    chk(monitor_active, mon);
    chk(charge_allowed, ok);
    chk(step_reduced, st);
    chk(fast_charge_scale, (st && ss < zs) ? ss : zs);
    vx = 13'h0096 - 13'h0032 * {11'h000, t0[4:3]};
    if (!cool) vx = 13'h0000;
    chk(vreg_target_mv, base_vreg_setting - vx);
    chk(system_undervoltage_sel, s1[4:3]);
  endtask : chk_out

  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    chk({fast_charge_scale, step_reduced, charge_allowed}, 16'h0029);
    repeat (10) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    for (int a = 8'h12; a < 8'h17; a++) begin
      rd(a[7:0], rv);
      chk(rv, 16'h0000);
      wr(a[7:0], 8'hFF);
      rd(a[7:0], rv);
      chk(rv, (a == 8'h13) ? s0 : (a == 8'h14) ? s1 :
          (a == 8'h15) ? t0 : 8'h00);
    end
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      if (r[31:29] == 3'h0) wr(8'h13, r[7:0]);
      if (r[28:27] == 2'h0) wr(8'h14, r[15:8]);
      if (r[26:25] == 2'h0) wr(8'h15, r[23:16]);
      r = rnd();
      @(posedge sys_clk);
      #1;
      case (r[2:0])
        3'h0: vbat_mv = rise_mv();
        3'h1: vbat_mv = rise_mv() - hys_mv();
        3'h2: vbat_mv = rise_mv() + 13'h0001;
        default: vbat_mv = rise_mv() - 13'h02BC + {4'h0, r[12:4]} % 13'h0320;
      endcase
      thermal_zone = (r[15:13] == 3'h7) ? 3'h1 : r[15:13] % 3'h5;
      charger_input_supply = r[16] | r[17];
      base_vreg_setting = 13'h1004 + {5'h00, r[25:18]};
      upd();
      repeat (5) @(posedge sys_clk);
      #1;
      chk_out();
    end
    rd(8'h13, rv);
    chk(rv, s0);
    tally_and_finish();
  end
endmodule : cstc_top_test

`default_nettype wire
